// ==== verilog/cssq_pkg.sv ====
// cssq_pkg: constants, carriers and state type of the channel scan sequencer
// assumes a single 25 MHz master clock and one asynchronous active-low reset
`default_nettype none

package cssq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam logic [3:0]  START_DELAY_CYCLES = 4'h4;

   // analog sample spacing per period class, in ns
   localparam int unsigned T_IVL0_NS = 62500;
   localparam int unsigned T_IVL1_NS = 156250;
   localparam int unsigned T_IVL2_NS = 312500;
   localparam int unsigned T_IVL3_NS = 625000;
   localparam int unsigned T_IVL4_NS = 1562500;

   // spacing is exact only for class 3; division rounds down so the sequence never stretches
   localparam int unsigned IVL0_CYCLES = T_IVL0_NS / CLK_PERIOD_NS;
   localparam int unsigned IVL1_CYCLES = T_IVL1_NS / CLK_PERIOD_NS;
   localparam int unsigned IVL2_CYCLES = T_IVL2_NS / CLK_PERIOD_NS;
   localparam int unsigned IVL3_CYCLES = T_IVL3_NS / CLK_PERIOD_NS;
   localparam int unsigned IVL4_CYCLES = T_IVL4_NS / CLK_PERIOD_NS;
   localparam logic [2:0]  IVL_CLASS_LAST = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // channel groups
   localparam logic [5:0] GRP0_CH = 6'h04;
   localparam logic [5:0] GRP1_CH = 6'h04;
   localparam logic [5:0] GRP2_CH = 6'h08;
   localparam logic [5:0] GRP3_CH = 6'h10;
   localparam logic [1:0] SEL_G0      = 2'h0;
   localparam logic [1:0] SEL_G01     = 2'h1;
   localparam logic [1:0] SEL_G012    = 2'h2;
   localparam logic [1:0] SEL_G0123   = 2'h3;
   localparam logic [5:0] BASE_SLOTS  = 6'h20;
   localparam int unsigned DIG_CH     = 16;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [4:0]  RST_CHANNEL  = 5'h00;
   localparam logic [15:0] RST_DIGITAL  = 16'h0000;
   localparam logic [15:0] RST_TIMER    = 16'h0000;
   localparam logic [5:0]  RST_SLOT     = 6'h00;
   localparam logic [2:0]  RST_OVERRIDE = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [1:0]        group_sel;
      logic [4:0]        period_sel;
      logic              remote_mode;
      logic [DIG_CH-1:0] digital;
   } cssq_pins_t;

   typedef struct packed {
      logic [5:0]  active_ch;
      logic [5:0]  slots;
      logic [15:0] interval;
      logic        invalid;
   } cssq_cfg_t;

   typedef enum logic [0:0] {
      ST_SETTLE,
      ST_RUN
   } cssq_state_t;

endpackage

`default_nettype wire

// ==== verilog/cssq_sync.sv ====
// cssq_sync: two-stage synchroniser for a bundle of pin levels
// assumes each bit is a slow static or level input from outside the clock domain
`timescale 1ns/1ns
`default_nettype none

module cssq_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_reg;

   ////////////////////////////////////////////////////////////////////////////
   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ==== verilog/cssq_top.sv ====
// cssq_top: channel scan sequencer, free-running after reset release
// assumes static strap pins, pin-level digital inputs and a same-clock command port
`timescale 1ns/1ns
`default_nettype none

module cssq_top
   import cssq_pkg::*;
#(
   parameter int unsigned IVL2_COUNT = IVL2_CYCLES,
   parameter int unsigned IVL3_COUNT = IVL3_CYCLES,
   parameter int unsigned IVL4_COUNT = IVL4_CYCLES
) (
   input  wire logic              CLOCK,
   input  wire logic              RESETN,
   input  wire logic [1:0]        ACTIVE_GROUP_SELECT,
   input  wire logic [4:0]        SCAN_PERIOD_SELECT,
   input  wire logic              REMOTE_TERMINAL_MODE,
   input  wire logic [DIG_CH-1:0] DIGITAL_IN,
   input  wire logic              CAN_CMD_VALID,
   input  wire logic [2:0]        CAN_CMD_PERIOD,
   output var  logic              SEQ_START,
   output var  logic              SEQ_RUNNING,
   output var  logic [DIG_CH-1:0] DIGITAL_CAPTURE,
   output var  logic              DIGITAL_VALID,
   output var  logic              ANALOG_SAMPLE,
   output var  logic [4:0]        ANALOG_CHANNEL,
   output var  logic [5:0]        ACTIVE_CHANNELS,
   output var  logic              CONFIG_INVALID,
   output var  logic              CMD_ACCEPTED,
   output var  logic              CMD_IGNORED
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation

   cssq_pins_t pins_raw;
   cssq_pins_t pins;

   assign pins_raw.group_sel   = ACTIVE_GROUP_SELECT;
   assign pins_raw.period_sel  = SCAN_PERIOD_SELECT;
   assign pins_raw.remote_mode = REMOTE_TERMINAL_MODE;
   assign pins_raw.digital     = DIGITAL_IN;

   cssq_sync #(
      .W ($bits(cssq_pins_t))
   ) u_pin_sync (
      .clk   (CLOCK),
      .rst_n (RESETN),
      .d     (pins_raw),
      .q     (pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // command port

   logic       ovr_valid_reg;
   logic       ovr_valid_next;
   logic [2:0] ovr_class_reg;
   logic [2:0] ovr_class_next;
   logic       cmd_acc_reg;
   logic       cmd_acc_next;
   logic       cmd_ign_reg;
   logic       cmd_ign_next;

   always_comb
   begin
      ovr_valid_next = ovr_valid_reg;
      ovr_class_next = ovr_class_reg;
      cmd_acc_next   = 1'b0;
      cmd_ign_next   = 1'b0;
      // override lapses when remote mode is left; pins rule again
      if (!pins.remote_mode)
      begin
         ovr_valid_next = 1'b0;
      end
      if (CAN_CMD_VALID)
      begin
         if (pins.remote_mode)
         begin
            ovr_valid_next = 1'b1;
            ovr_class_next = CAN_CMD_PERIOD;
            cmd_acc_next   = 1'b1;
         end
         else
         begin
            cmd_ign_next = 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ovr_valid_reg <= 1'b0;
         ovr_class_reg <= RST_OVERRIDE;
         cmd_acc_reg   <= 1'b0;
         cmd_ign_reg   <= 1'b0;
      end
      else
      begin
         ovr_valid_reg <= ovr_valid_next;
         ovr_class_reg <= ovr_class_next;
         cmd_acc_reg   <= cmd_acc_next;
         cmd_ign_reg   <= cmd_ign_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // live configuration from straps and override

   cssq_cfg_t  live_cfg;
   logic [2:0] ivl_class;
   logic [1:0] slot_shift;
   logic [5:0] raw_slots;

   function automatic logic [15:0] interval_of(input logic [2:0] cls);
      logic [15:0] v;
      v = 16'(IVL4_COUNT);
      case (cls)
         3'h0:    v = 16'(IVL0_CYCLES);
         3'h1:    v = 16'(IVL1_CYCLES);
         3'h2:    v = 16'(IVL2_COUNT);
         3'h3:    v = 16'(IVL3_COUNT);
         default: v = 16'(IVL4_COUNT);
      endcase
      return v;
   endfunction

   always_comb
   begin
      // the command takes priority over the period class straps
      ivl_class = (ovr_valid_reg && pins.remote_mode) ?
                  ovr_class_reg : pins.period_sel[4:2];
      slot_shift = pins.period_sel[1:0];
      raw_slots  = BASE_SLOTS >> slot_shift;
      case (pins.group_sel)
         SEL_G0:    live_cfg.active_ch = GRP0_CH;
         SEL_G01:   live_cfg.active_ch = GRP0_CH + GRP1_CH;
         SEL_G012:  live_cfg.active_ch = GRP0_CH + GRP1_CH + GRP2_CH;
         SEL_G0123: live_cfg.active_ch = GRP0_CH + GRP1_CH + GRP2_CH + GRP3_CH;
         default:   live_cfg.active_ch = GRP0_CH;
      endcase
      live_cfg.interval = interval_of(ivl_class);
      // too short a sequence is stretched so no channel is skipped
      live_cfg.invalid = (raw_slots < live_cfg.active_ch) ||
                         (ivl_class > IVL_CLASS_LAST);
      // one slot per channel at least
      live_cfg.slots = (raw_slots < live_cfg.active_ch) ?
                       live_cfg.active_ch : raw_slots;
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   cssq_state_t       state_reg;
   cssq_state_t       state_next;
   logic [3:0]        settle_reg;
   logic [3:0]        settle_next;
   logic [15:0]       timer_reg;
   logic [15:0]       timer_next;
   logic [5:0]        slot_reg;
   logic [5:0]        slot_next;
   cssq_cfg_t         cfg_reg;
   cssq_cfg_t         cfg_next;
   cssq_cfg_t         use_cfg;
   logic              first_slot;
   logic              seq_start_reg;
   logic              seq_start_next;
   logic              running_reg;
   logic              running_next;
   logic [DIG_CH-1:0] dig_reg;
   logic [DIG_CH-1:0] dig_next;
   logic              dig_valid_reg;
   logic              dig_valid_next;
   logic              an_sample_reg;
   logic              an_sample_next;
   logic [4:0]        an_chan_reg;
   logic [4:0]        an_chan_next;

   always_comb
   begin
      state_next     = state_reg;
      settle_next    = settle_reg;
      timer_next     = timer_reg;
      slot_next      = slot_reg;
      cfg_next       = cfg_reg;
      running_next   = running_reg;
      dig_next       = dig_reg;
      an_chan_next   = an_chan_reg;
      seq_start_next = 1'b0;
      dig_valid_next = 1'b0;
      an_sample_next = 1'b0;
      first_slot     = (slot_reg == RST_SLOT);
      // straps are only looked at between sequences
      use_cfg        = first_slot ? live_cfg : cfg_reg;
      case (state_reg)
         ST_SETTLE:
         begin
            // self start
            // waits for the synchronised straps to be valid
            if (settle_reg == 4'h0)
            begin
               state_next   = ST_RUN;
               running_next = 1'b1;
               timer_next   = RST_TIMER;
               slot_next    = RST_SLOT;
            end
            else
            begin
               settle_next = settle_reg - 4'h1;
            end
         end
         ST_RUN:
         begin
            if (timer_reg == 16'h0000)
            begin
               timer_next = use_cfg.interval - 16'h0001;
               if (first_slot)
               begin
                  cfg_next       = live_cfg;
                  seq_start_next = 1'b1;
                  dig_next       = pins.digital;
                  dig_valid_next = 1'b1;
               end
               if (slot_reg < use_cfg.active_ch)
               begin
                  an_sample_next = 1'b1;
                  an_chan_next   = slot_reg[4:0];
               end
               // wrap straight into the next sequence
               if (slot_reg == use_cfg.slots - 6'h01)
               begin
                  slot_next = RST_SLOT;
               end
               else
               begin
                  slot_next = slot_reg + 6'h01;
               end
            end
            else
            begin
               timer_next = timer_reg - 16'h0001;
            end
         end
         default:
         begin
            state_next = ST_SETTLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_reg     <= ST_SETTLE;
         settle_reg    <= START_DELAY_CYCLES;
         timer_reg     <= RST_TIMER;
         slot_reg      <= RST_SLOT;
         cfg_reg       <= '0;
         running_reg   <= 1'b0;
         seq_start_reg <= 1'b0;
         dig_reg       <= RST_DIGITAL;
         dig_valid_reg <= 1'b0;
         an_sample_reg <= 1'b0;
         an_chan_reg   <= RST_CHANNEL;
      end
      else
      begin
         state_reg     <= state_next;
         settle_reg    <= settle_next;
         timer_reg     <= timer_next;
         slot_reg      <= slot_next;
         cfg_reg       <= cfg_next;
         running_reg   <= running_next;
         seq_start_reg <= seq_start_next;
         dig_reg       <= dig_next;
         dig_valid_reg <= dig_valid_next;
         an_sample_reg <= an_sample_next;
         an_chan_reg   <= an_chan_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops

   assign SEQ_START       = seq_start_reg;
   assign SEQ_RUNNING     = running_reg;
   assign DIGITAL_CAPTURE = dig_reg;
   assign DIGITAL_VALID   = dig_valid_reg;
   assign ANALOG_SAMPLE   = an_sample_reg;
   assign ANALOG_CHANNEL  = an_chan_reg;
   assign ACTIVE_CHANNELS = cfg_reg.active_ch;
   assign CONFIG_INVALID  = cfg_reg.invalid;
   assign CMD_ACCEPTED    = cmd_acc_reg;
   assign CMD_IGNORED     = cmd_ign_reg;

endmodule

`default_nettype wire

// ==== tb/cssq_top_asserts.sv ====
// cssq_top_asserts: port-level checks of the scan sequencer
// assumes interval counts of at least nine cycles
`timescale 1ns/1ns
`default_nettype none

module cssq_top_asserts
   import cssq_pkg::*;
(
   input  wire logic              CLOCK,
   input  wire logic              RESETN,
   input  wire logic              REMOTE_TERMINAL_MODE,
   input  wire logic              CAN_CMD_VALID,
   input  wire logic              SEQ_START,
   input  wire logic              SEQ_RUNNING,
   input  wire logic [DIG_CH-1:0] DIGITAL_CAPTURE,
   input  wire logic              DIGITAL_VALID,
   input  wire logic              ANALOG_SAMPLE,
   input  wire logic [4:0]        ANALOG_CHANNEL,
   input  wire logic              CMD_ACCEPTED,
   input  wire logic              CMD_IGNORED
);
   logic [3:0]  age_reg;
   logic [15:0] gap_reg;
   logic [15:0] ivl_reg;
   logic        first_reg;

   ////////////////////////////////////////
   // age saturates; only the first cycles after release matter
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         age_reg   <= 4'h0;
         gap_reg   <= 16'h0000;
         ivl_reg   <= 16'h0000;
         first_reg <= 1'b0;
      end
      else
      begin
         age_reg   <= (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
         gap_reg   <= ANALOG_SAMPLE ? 16'h0001 : gap_reg + 16'h0001;
         first_reg <= ANALOG_SAMPLE ? SEQ_START : first_reg;
         ivl_reg   <= (ANALOG_SAMPLE && first_reg) ? gap_reg : ivl_reg;
      end
   end

   ////////////////////////////////////////
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);

   a_start_digital: assert property (SEQ_START == DIGITAL_VALID)
      else $error("digital strobe apart from start");
   a_first_channel: assert property (
      SEQ_START |-> ANALOG_SAMPLE && ANALOG_CHANNEL == 5'h00)
      else $error("sequence not opened on channel 0");
   a_channel_order: assert property (
      ANALOG_SAMPLE && !SEQ_START |-> ANALOG_CHANNEL == $past(ANALOG_CHANNEL) + 5'h01)
      else $error("channel order broken");
   a_even_spacing: assert property (
      ANALOG_SAMPLE && !SEQ_START && !first_reg |-> gap_reg == ivl_reg)
      else $error("uneven sample spacing");
   a_capture_held: assert property (!DIGITAL_VALID |-> $stable(DIGITAL_CAPTURE))
      else $error("capture changed mid sequence");
   a_auto_start: assert property (
      age_reg == 4'h5 |-> SEQ_RUNNING && !SEQ_START ##1 SEQ_START)
      else $error("no start after reset");
   a_start_single: assert property (SEQ_START |=> !SEQ_START [*8])
      else $error("start pulse too long");
   a_cmd_refused: assert property (
      CAN_CMD_VALID && !REMOTE_TERMINAL_MODE && !$past(REMOTE_TERMINAL_MODE)
      && !$past(REMOTE_TERMINAL_MODE, 2) |=> CMD_IGNORED && !CMD_ACCEPTED)
      else $error("command outside remote mode taken");
   a_cmd_taken: assert property (
      age_reg > 4'h3 && CAN_CMD_VALID && REMOTE_TERMINAL_MODE && $past(REMOTE_TERMINAL_MODE)
      && $past(REMOTE_TERMINAL_MODE, 2) |=> CMD_ACCEPTED && !CMD_IGNORED)
      else $error("remote command not taken");
   a_cmd_quiet: assert property (
      !CAN_CMD_VALID |=> !CMD_ACCEPTED && !CMD_IGNORED)
      else $error("command answer without command");
endmodule

bind cssq_top cssq_top_asserts chk_u (
   .CLOCK(CLOCK), .RESETN(RESETN), .REMOTE_TERMINAL_MODE(REMOTE_TERMINAL_MODE),
   .CAN_CMD_VALID(CAN_CMD_VALID), .SEQ_START(SEQ_START), .SEQ_RUNNING(SEQ_RUNNING),
   .DIGITAL_CAPTURE(DIGITAL_CAPTURE), .DIGITAL_VALID(DIGITAL_VALID),
   .ANALOG_SAMPLE(ANALOG_SAMPLE), .ANALOG_CHANNEL(ANALOG_CHANNEL),
   .CMD_ACCEPTED(CMD_ACCEPTED), .CMD_IGNORED(CMD_IGNORED)
);

`default_nettype wire

// ==== tb/cssq_sensor_model.sv ====
// cssq_sensor_model: board straps and digital sensor levels
// assumes the bench calls set_pins; levels move on a falling edge only
`timescale 1ns/1ns
`default_nettype none

module cssq_sensor_model
   import cssq_pkg::*;
(
   input  wire logic       clk,
   output var  cssq_pins_t pins
);
   initial pins = '0;

   task automatic set_pins(input logic [1:0] gs, input logic [4:0] ps,
                           input logic rm, input logic [15:0] dg);
      @(negedge clk);
      pins = '{gs, ps, rm, dg};
   endtask
endmodule

`default_nettype wire

// ==== tb/test_channel_scan_sequencer.sv ====
// test_channel_scan_sequencer: self-checking bench of the scan sequencer
// assumes short interval counts and the sensor model on the pin side
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) \
   begin \
      check_count++; \
      if ((e) !== (g)) \
      begin \
         errors++; \
         $display("wrong value %s exp %0h got %0h", nm, e, g); \
      end \
   end

module test_channel_scan_sequencer
   import cssq_pkg::*;
;
   localparam int         N2   = 20;
   localparam int         N3   = 30;
   localparam int         N4   = 40;
   localparam logic [4:0] PER4 = 5'h0b;

   logic              clock;
   logic              resetn;
   logic              cmd_valid;
   logic [2:0]        cmd_period;
   cssq_pins_t        pins;
   logic              seq_start;
   logic              running;
   logic [DIG_CH-1:0] dig_cap;
   logic              dig_valid;
   logic              an_sample;
   logic [4:0]        an_ch;
   logic [5:0]        act_ch;
   logic              cfg_inv;
   logic              cmd_acc;
   logic              cmd_ign;
   int                errors;
   int                check_count;
   int                cycles;

   cssq_sensor_model part_u (.clk(clock), .pins(pins));

   cssq_top #(.IVL2_COUNT(N2), .IVL3_COUNT(N3), .IVL4_COUNT(N4)) dut_u (
      .CLOCK(clock), .RESETN(resetn), .ACTIVE_GROUP_SELECT(pins.group_sel),
      .SCAN_PERIOD_SELECT(pins.period_sel), .REMOTE_TERMINAL_MODE(pins.remote_mode),
      .DIGITAL_IN(pins.digital), .CAN_CMD_VALID(cmd_valid), .CAN_CMD_PERIOD(cmd_period),
      .SEQ_START(seq_start), .SEQ_RUNNING(running), .DIGITAL_CAPTURE(dig_cap),
      .DIGITAL_VALID(dig_valid), .ANALOG_SAMPLE(an_sample), .ANALOG_CHANNEL(an_ch),
      .ACTIVE_CHANNELS(act_ch), .CONFIG_INVALID(cfg_inv), .CMD_ACCEPTED(cmd_acc),
      .CMD_IGNORED(cmd_ign)
   );

   always #20 clock = ~clock;

   // ceiling far above the roughly 7300 cycles planned
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         end_sim();
      end
   end

   ////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wait_start();
      int n;
      n = 0;
      do
      begin
         @(negedge clock);
         n++;
      end
      while (seq_start !== 1'b1 && n < 3000);
      `CHK("start_seen", 1'b1, seq_start)
   endtask

   // called on the falling edge that shows a start
   // sl is the slot count; idle slots past the channels carry no sample
   task automatic measure(input logic [5:0] c, input int n, input int sl);
      int t;
      int k;
      t = 0;
      k = 0;
      do
      begin
         if (an_sample === 1'b1)
         begin
            `CHK("channel", 5'(k), an_ch)
            `CHK("spacing", k * n, t)
            k++;
         end
         @(negedge clock);
         t++;
      end
      while (seq_start !== 1'b1 && t < 3000);
      `CHK("samples", c, 6'(k))
      `CHK("period", n * sl, t)
   endtask

   task automatic send_cmd(input logic [2:0] c, input logic acc);
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_period = c;
      @(negedge clock);
      cmd_valid = 1'b0;
      `CHK("cmd_accepted", acc, cmd_acc)
      `CHK("cmd_ignored", ~acc, cmd_ign)
   endtask

   ////////////////////////////////////////
   task automatic t_startup();
      int n;
      n = 0;
      part_u.set_pins(2'h0, PER4, 1'b0, 16'h3c3c);
      resetn = 1'b0;
      repeat (10) @(negedge clock);
      `CHK("running_reset", 1'b0, running)
      resetn = 1'b1;
      do
      begin
         @(negedge clock);
         n++;
      end
      while (seq_start !== 1'b1 && n < 20);
      `CHK("start_delay", 6, n)
      `CHK("capture", 16'h3c3c, dig_cap)
      `CHK("running", 1'b1, running)
      `CHK("channels", 6'h04, act_ch)
      measure(6'h04, N2, 4);
   endtask

   task automatic t_groups();
      logic [15:0] dg;
      for (int s = 0; s < 4; s++)
      begin
         dg = {16{s[0]}} ^ 16'ha5c3;
         part_u.set_pins(2'(s), {3'h2, 2'(3 - s)}, 1'b0, dg);
         wait_start();
         `CHK("capture", dg, dig_cap)
         `CHK("dig_valid", 1'b1, dig_valid)
         `CHK("channels", 6'h04 << s, act_ch)
         `CHK("invalid", 1'b0, cfg_inv)
         measure(6'h04 << s, N2, 4 << s);
      end
   endtask

   task automatic t_invalid();
      part_u.set_pins(2'h3, PER4, 1'b0, 16'hffff);
      wait_start();
      `CHK("invalid", 1'b1, cfg_inv)
      `CHK("capture", 16'hffff, dig_cap)
      measure(6'h20, N2, 32);
   endtask

   // class four straps, full slot count: four samples then idle slots
   task automatic t_idle_slots();
      part_u.set_pins(2'h0, 5'h10, 1'b0, 16'h1234);
      wait_start();
      `CHK("channels", 6'h04, act_ch)
      `CHK("invalid", 1'b0, cfg_inv)
      `CHK("capture", 16'h1234, dig_cap)
      measure(6'h04, N4, 32);
   endtask

   task automatic t_commands();
      part_u.set_pins(2'h0, PER4, 1'b0, 16'h0ff0);
      send_cmd(3'h3, 1'b0);
      wait_start();
      measure(6'h04, N2, 4);
      part_u.set_pins(2'h0, PER4, 1'b1, 16'h0ff0);
      repeat (3) @(negedge clock);
      send_cmd(3'h3, 1'b1);
      wait_start();
      measure(6'h04, N3, 4);
      // class past the last one is flagged and runs at the slowest spacing
      send_cmd(3'h5, 1'b1);
      wait_start();
      `CHK("invalid", 1'b1, cfg_inv)
      measure(6'h04, N4, 4);
      part_u.set_pins(2'h0, PER4, 1'b0, 16'h0ff0);
      wait_start();
      `CHK("invalid", 1'b0, cfg_inv)
      measure(6'h04, N2, 4);
   endtask

   initial
   begin
      clock = 1'b0;
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_period = 3'h0;
      t_startup();
      t_groups();
      t_invalid();
      t_idle_slots();
      t_commands();
      t_startup();
      end_sim();
   end
endmodule

`default_nettype wire
